// [hdl/sps_sequencer.sv]
// Mode sequencer of a system basis chip with APB register slave.
// Assumes APB master on clk, fault and supply inputs asynchronous.
//
// What this block does
// R1 - Power-up enters Normal Request, transceiver on, main on, aux off.
// R2 - No watchdog write in 350 ms of Normal Request causes reset, retry.
// R3 - Watchdog flag held low in Normal Request before the first write.
// R4 - Watchdog write enters Normal: aux on, flag released, reset high.
// R5 - Missed refresh in Normal asserts reset, returns to Normal Request.
// R6 - Undervoltage with Stop selected: Reset mode, reset low, flag high.
// R7 - Stop-selected undervoltage also drives interrupt low in Reset mode.
// R8 - Overload removed: restart in Normal Request.
// R9 - Sleep selected, battery flag cleared: hold Reset for 100 ms.
// R10 - After that 100 ms hold, Sleep with both regulators off.
// R11 - During the 100 ms hold reset and interrupt low, flag high.
// R12 - Four status bits read one while their condition is present.
// R13 - Interrupt output low when a masked-in condition is set.
// R14 - Status clears only after source read and condition recovered.
// R15 - Windows timed by internal counters restarted at mode entry.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module sps_sequencer
(
    input wire logic clk, // Block clock, 125 MHz
    input wire logic srst, // Synchronous reset, power-up
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire sps_pkg::sps_fault_t fault_in, // Raw fault levels
    input wire logic main_uv_in, // Main supply undervoltage
    output logic reset_out_n, // Active-low reset pin
    output logic irq_out_n, // Active-low interrupt pin
    output logic watchdog_flag_out_n, // Active-low watchdog flag
    output sps_pkg::sps_power_t power_out // Regulator enables
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [4:0] raw_w;
    logic [4:0] sync_w;
    assign raw_w = {main_uv_in, fault_in};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            sps_sync u_sync
            (
                .clk(clk),
                .srst(srst),
                .d(raw_w[gi]),
                .q(sync_w[gi])
            );
        end
    endgenerate

    logic uv_s;
    logic [3:0] cond_s;
    assign uv_s = sync_w[4];
    assign cond_s = sync_w[3:0];

    ////////////////////////////////////////////////////////////////////
    // APB decode
    logic acc_w;
    logic wr_w;
    logic rd_w;
    logic hit_w;
    assign acc_w = psel && penable;
    assign wr_w = acc_w && pwrite;
    assign rd_w = acc_w && !pwrite;
    assign hit_w = paddr == sps_pkg::OFF_WD_TIMING
        || paddr == sps_pkg::OFF_CTRL || paddr == sps_pkg::OFF_STATUS
        || paddr == sps_pkg::OFF_MASK || paddr == sps_pkg::OFF_MODE
        || paddr == sps_pkg::OFF_SRC;

    logic wd_write_w;
    assign wd_write_w = wr_w && paddr == sps_pkg::OFF_WD_TIMING;

    ////////////////////////////////////////////////////////////////////
    // Control, mask and battery-fail registers
    logic [1:0] ctrl_r;
    logic [3:0] mask_r;
    logic battery_fail_flag_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_r <= sps_pkg::CTRL_RST;
            mask_r <= sps_pkg::MASK_RST;
        end
        else if (wr_w && paddr == sps_pkg::OFF_CTRL)
            ctrl_r <= pwdata[1:0];
        else if (wr_w && paddr == sps_pkg::OFF_MASK)
            mask_r <= pwdata[3:0];
    end

    // Battery-fail is set at power-up; writing one to its bit clears it
    always_ff @(posedge clk)
    begin
        if (srst)
            battery_fail_flag_r <= sps_pkg::BATT_FAIL_RST;
        else if (wr_w && paddr == sps_pkg::OFF_CTRL
                 && pwdata[sps_pkg::CTRL_BATT_FAIL_CLR_BIT])
            battery_fail_flag_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Latched source flags and interrupt status
    logic [3:0] src_r;
    logic [3:0] status_r;
    logic src_rd_w;
    assign src_rd_w = rd_w && paddr == sps_pkg::OFF_SRC;

    // Latch sets win over the read clear, so a live fault is never lost
    always_ff @(posedge clk)
    begin
        if (srst)
            src_r <= '0;
        else if (src_rd_w)
            src_r <= cond_s; // R14
        else
            src_r <= src_r | cond_s; // R12
    end

    // Status mirrors the latch and live conditions; a W1C write leaves it unchanged
    always_ff @(posedge clk)
    begin
        if (srst)
            status_r <= '0;
        else if (wr_w && paddr == sps_pkg::OFF_STATUS)
            status_r <= (src_r | cond_s) | (status_r & ~pwdata[3:0]
                        & (src_r | cond_s)); // R14
        else
            status_r <= src_r | cond_s; // R12
    end

    ////////////////////////////////////////////////////////////////////
    // Mode state machine
    sps_pkg::sps_mode_t mode_r;
    sps_pkg::sps_mode_t mode_nxt;
    logic enter_w;
    logic wd_exp;
    logic hold_exp;

    assign enter_w = mode_nxt != mode_r || srst;

    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            sps_pkg::MODE_NORMAL_REQ, sps_pkg::MODE_NORMAL:
            begin
                if (uv_s && ctrl_r[sps_pkg::CTRL_SLEEP_SEL_BIT]
                    && !battery_fail_flag_r)
                    mode_nxt = sps_pkg::MODE_RESET_SLEEP; // R9
                else if (uv_s)
                    mode_nxt = sps_pkg::MODE_RESET_STOP; // R6
                else if (wd_write_w)
                    mode_nxt = sps_pkg::MODE_NORMAL; // R4
                else if (wd_exp)
                    mode_nxt = sps_pkg::MODE_WD_RESET; // R2 R5
            end
            sps_pkg::MODE_WD_RESET:
                mode_nxt = sps_pkg::MODE_NORMAL_REQ; // R2 R5
            sps_pkg::MODE_RESET_STOP:
            begin
                if (!uv_s)
                    mode_nxt = sps_pkg::MODE_NORMAL_REQ; // R8
            end
            sps_pkg::MODE_RESET_SLEEP:
            begin
                if (hold_exp)
                    mode_nxt = sps_pkg::MODE_SLEEP; // R10
            end
            sps_pkg::MODE_SLEEP:
                mode_nxt = sps_pkg::MODE_SLEEP;
            default:
                mode_nxt = sps_pkg::MODE_NORMAL_REQ;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            mode_r <= sps_pkg::MODE_NORMAL_REQ; // R1
        else
            mode_r <= mode_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Timers restarted on mode entry; refresh also restarts the window
    logic in_wd_mode_w;
    assign in_wd_mode_w = mode_r == sps_pkg::MODE_NORMAL_REQ
        || mode_r == sps_pkg::MODE_NORMAL;

    sps_timer u_wd_timer
    (
        .clk(clk),
        .srst(srst),
        .start(enter_w || wd_write_w), // R15
        .run(in_wd_mode_w),
        .load(sps_pkg::CNT_W'(sps_pkg::WD_WINDOW_CYC)),
        .expired(wd_exp)
    );

    sps_timer u_hold_timer
    (
        .clk(clk),
        .srst(srst),
        .start(enter_w), // R15
        .run(mode_r == sps_pkg::MODE_RESET_SLEEP),
        .load(sps_pkg::CNT_W'(sps_pkg::RST_HOLD_CYC)),
        .expired(hold_exp)
    );

    ////////////////////////////////////////////////////////////////////
    // Pin outputs, registered from the next mode
    logic irq_any_w;
    assign irq_any_w = |(status_r & mask_r);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            reset_out_n <= 1'b0;
            watchdog_flag_out_n <= 1'b0;
            irq_out_n <= 1'b1;
            power_out <= sps_pkg::POWER_RST; // R1
        end
        else
        begin
            reset_out_n <= mode_nxt == sps_pkg::MODE_NORMAL; // R4 R5 R6
            watchdog_flag_out_n <= mode_nxt != sps_pkg::MODE_NORMAL_REQ
                && mode_nxt != sps_pkg::MODE_WD_RESET; // R3 R6 R11
            irq_out_n <= !(irq_any_w // R13
                || mode_nxt == sps_pkg::MODE_RESET_STOP // R7
                || mode_nxt == sps_pkg::MODE_RESET_SLEEP); // R11
            power_out.main_reg_en <= mode_nxt != sps_pkg::MODE_SLEEP; // R10
            power_out.aux_regulator_en <=
                mode_nxt == sps_pkg::MODE_NORMAL; // R1 R4 R10
            power_out.transmit_receive_mode <=
                mode_nxt != sps_pkg::MODE_SLEEP; // R1
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB answer: zero wait states, error on unmapped address
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_w;
            case (paddr)
                sps_pkg::OFF_CTRL: prdata <= {29'h0, battery_fail_flag_r,
                                              ctrl_r};
                sps_pkg::OFF_STATUS: prdata <= {28'h0, status_r};
                sps_pkg::OFF_MASK: prdata <= {28'h0, mask_r};
                sps_pkg::OFF_MODE: prdata <= {29'h0, mode_r};
                sps_pkg::OFF_SRC: prdata <= {28'h0, src_r};
                default: prdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_wd_flag_low: assert property (@(posedge clk) // R3
        disable iff (srst) mode_r == sps_pkg::MODE_NORMAL_REQ
        ##1 mode_r == sps_pkg::MODE_NORMAL_REQ |-> !watchdog_flag_out_n)
        else $error("flag high in normal request");
    a_wd_write_normal: assert property (@(posedge clk) // R4
        disable iff (srst) wd_write_w && in_wd_mode_w && !uv_s
        |=> mode_r == sps_pkg::MODE_NORMAL && reset_out_n
        && power_out.aux_regulator_en)
        else $error("write did not enter normal");
    a_wd_expire_rst: assert property (@(posedge clk) // R2
        disable iff (srst) wd_exp && in_wd_mode_w && !uv_s && !wd_write_w
        |=> !reset_out_n ##1 mode_r == sps_pkg::MODE_NORMAL_REQ)
        else $error("expiry did not reset");
    a_stop_uv_pins: assert property (@(posedge clk) // R6 R7
        disable iff (srst) mode_r == sps_pkg::MODE_RESET_STOP
        && $past(mode_r) == sps_pkg::MODE_RESET_STOP
        |-> !reset_out_n && !irq_out_n && watchdog_flag_out_n)
        else $error("stop reset pins wrong");
    a_stop_recover: assert property (@(posedge clk) // R8
        disable iff (srst) mode_r == sps_pkg::MODE_RESET_STOP && !uv_s
        |=> mode_r == sps_pkg::MODE_NORMAL_REQ)
        else $error("no restart after overload");
    a_sleep_entry: assert property (@(posedge clk) // R10
        disable iff (srst) hold_exp && mode_r == sps_pkg::MODE_RESET_SLEEP
        |=> mode_r == sps_pkg::MODE_SLEEP ##1 !power_out.main_reg_en
        && !power_out.aux_regulator_en)
        else $error("sleep entry wrong");
    // Whole hold, not only its first cycle
    a_hold_pins: assert property (@(posedge clk) // R11
        disable iff (srst) mode_r == sps_pkg::MODE_RESET_SLEEP
        |-> !reset_out_n && !irq_out_n && watchdog_flag_out_n)
        else $error("hold pins wrong");
    a_irq_mask: assert property (@(posedge clk) // R13
        disable iff (srst) |(status_r & mask_r) |=> !irq_out_n)
        else $error("masked irq not driven");
    // Every live condition shows in status one edge later
    a_status_live: assert property (@(posedge clk) // R12
        disable iff (srst) |cond_s
        |=> (status_r & $past(cond_s)) == $past(cond_s))
        else $error("status missed condition");

endmodule

// [hdl/sps_pkg.sv]
// Package for the supply mode sequencer: register map, fields, timings,
// mode encoding and the struct carriers.
// Assumes a 125 MHz system clock and 32-bit APB.
package sps_pkg;

    // Clock rate and timing
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned WD_WINDOW_MS = 350;
    localparam int unsigned RST_HOLD_MS = 100;
    localparam int unsigned WD_WINDOW_CYC = WD_WINDOW_MS * (CLK_HZ / 1000);
    localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 26;

    // Register byte offsets
    localparam logic [7:0] OFF_WD_TIMING = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_MODE = 8'h10;
    localparam logic [7:0] OFF_SRC = 8'h14;

    // Control register fields
    localparam int unsigned CTRL_SLEEP_SEL_BIT = 0;
    localparam int unsigned CTRL_BATT_FAIL_CLR_BIT = 1;

    // Interrupt bit positions
    localparam int unsigned IRQ_CAN_FAIL_BIT = 0;
    localparam int unsigned IRQ_TEMP_WARN_BIT = 1;
    localparam int unsigned IRQ_HS_OVERTEMP_BIT = 2;
    localparam int unsigned IRQ_SUPLOW_BIT = 3;
    localparam int unsigned IRQ_W = 4;

    // Reset values
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic BATT_FAIL_RST = 1'b1;
    // Main regulator on, aux off, transceiver on
    localparam logic [2:0] POWER_RST = 3'h5;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_NORMAL_REQ = 3'b000,
        MODE_NORMAL = 3'b001,
        MODE_RESET_STOP = 3'b010,
        MODE_RESET_SLEEP = 3'b011,
        MODE_SLEEP = 3'b100,
        MODE_WD_RESET = 3'b101
    } sps_mode_t;

    // Raw fault inputs grouped
    typedef struct packed {
        logic supply_low;
        logic high_side_overtemp;
        logic main_reg_temp_warning;
        logic can_failure;
    } sps_fault_t;

    // Regulator and transceiver enables
    typedef struct packed {
        logic main_reg_en;
        logic aux_regulator_en;
        logic transmit_receive_mode;
    } sps_power_t;

endpackage

// [hdl/sps_sync.sv]
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes clk is the block clock and srst is synchronous active high.
`timescale 1ns/100ps
module sps_sync
(
    input wire logic clk, // Block clock
    input wire logic srst, // Synchronous reset
    input wire logic d, // Asynchronous level
    output logic q // Synchronised level
);

    logic meta_r;

    // First flop feeds only the second one
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

// [hdl/sps_timer.sv]
// Down-counting mode timer with restart and one-cycle expiry pulse.
// Assumes a single clock; load value is given at restart.
`timescale 1ns/100ps
module sps_timer
(
    input wire logic clk, // Block clock
    input wire logic srst, // Synchronous reset
    input wire logic start, // Restart the count
    input wire logic run, // Count while high
    input wire logic [sps_pkg::CNT_W-1:0] load, // Cycles to time
    output logic expired // Pulse when count ends
);

    logic [sps_pkg::CNT_W-1:0] cnt_r;
    logic active_r;

    // Counter reloads on every restart so a new mode gets a full window
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            // Reset is a mode entry too, so the window runs from release
            cnt_r <= load - 1'b1;
            active_r <= 1'b1;
            expired <= 1'b0;
        end
        else if (start)
        begin
            cnt_r <= load - 1'b1;
            active_r <= 1'b1;
            expired <= 1'b0;
        end
        else if (!run)
        begin
            active_r <= 1'b0;
            expired <= 1'b0;
        end
        else if (active_r && cnt_r == '0)
        begin
            active_r <= 1'b0;
            expired <= 1'b1;
        end
        else
        begin
            cnt_r <= active_r ? cnt_r - 1'b1 : cnt_r;
            expired <= 1'b0;
        end
    end

endmodule

// [tb/sps_host_model.sv]
// Host microcontroller model: APB master that services the watchdog
// and acknowledges interrupt sources of the sequencer.
// Assumes one clock and a slave that answers with pready.
`timescale 1ns/100ps
module sps_host_model
(
    input wire logic clk, // Block clock
    output logic psel, // APB select
    output logic penable, // APB enable
    output logic pwrite, // APB write
    output logic [7:0] paddr, // APB byte address
    output logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr // APB error
);
    int hangs;

    ////////////////////////////////////////////////////////////////////
    // Idle bus at time zero, no transfer before the bench asks
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hangs = 0;
    end

    ////////////////////////////////////////////////////////////////////
    // One APB transfer; a fresh edge first so psel is never set twice
    task automatic xfer(input logic wr, input logic [7:0] addr,
        input logic [31:0] wdata, output logic [31:0] rdata,
        output logic err);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Wait for the answer; only the bench timeout ends a dead wait
        while (pready !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        // Zero wait states are promised, so any transfer with an extra cycle is counted
        if (n != 0)
            hangs++;
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Any written value counts as a service of the watchdog
    task automatic kick_watchdog;
        logic [31:0] q;
        logic e;
        xfer(1'b1, sps_pkg::OFF_WD_TIMING, 32'h0000_A5A5, q, e);
    endtask

    // Reading the source latch lets recovered flags clear
    task automatic ack_sources(output logic [31:0] q);
        logic e;
        xfer(1'b0, sps_pkg::OFF_SRC, 32'h0, q, e);
    endtask
endmodule

// [tb/sps_tb_top.sv]
// Self-checking bench of the supply mode sequencer.
// Assumes package timings are the full ones, so only window starts
// and holds are seen, never their expiry.
`timescale 1ns/100ps
module sbc_powerup_fault_mode_sequencer_tb_top;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, main_uv_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, bit_v, q;
    logic reset_out_n, irq_out_n, watchdog_flag_out_n;
    sps_pkg::sps_fault_t fault_in;
    sps_pkg::sps_power_t power_out;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    sps_sequencer DUT (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_in(fault_in), .main_uv_in(main_uv_in),
        .reset_out_n(reset_out_n), .irq_out_n(irq_out_n),
        .watchdog_flag_out_n(watchdog_flag_out_n), .power_out(power_out));

    sps_host_model HOST (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_fail == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic eexp);
        logic [31:0] r;
        logic e;
        HOST.xfer(1'b1, a, d, r, e);
        check({31'h0, e}, {31'h0, eexp}, "write error flag");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input logic eexp, input string msg);
        logic [31:0] r;
        logic e;
        HOST.xfer(1'b0, a, 32'h0, r, e);
        check({31'h0, e}, {31'h0, eexp}, "read error flag");
        check(r, exp, msg);
    endtask

    // Reset, interrupt and watchdog flag pins in that order
    task automatic pins(input logic [2:0] exp, input string msg);
        check({29'h0, reset_out_n, irq_out_n, watchdog_flag_out_n},
            {29'h0, exp}, msg);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Cycle ceiling; the tests need about 1400 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        srst = 1'b1;
        fault_in = '0;
        main_uv_in = 1'b0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        idle(2);
        pins(3'b010, "pins after reset");
        check({29'h0, power_out}, 32'h5, "power after reset");
        rd(sps_pkg::OFF_MODE, 32'h0, 1'b0, "mode after reset");
        rd(sps_pkg::OFF_CTRL, 32'h4, 1'b0, "ctrl reset value");
        rd(sps_pkg::OFF_MASK, 32'h0, 1'b0, "mask reset value");
        rd(sps_pkg::OFF_STATUS, 32'h0, 1'b0, "status reset value");
        rd(sps_pkg::OFF_WD_TIMING, 32'h0, 1'b0, "watchdog reads zero");
        wr(8'h20, 32'hF, 1'b1);
        rd(8'h20, 32'h0, 1'b1, "unmapped read");
        rd(sps_pkg::OFF_MASK, 32'h0, 1'b0, "unmapped write ignored");
        idle(50);
        pins(3'b010, "flag held before first write");
        HOST.kick_watchdog();
        idle(2);
        pins(3'b111, "pins in normal");
        check({29'h0, power_out}, 32'h7, "aux on in normal");
        rd(sps_pkg::OFF_MODE, 32'h1, 1'b0, "mode normal");
        // Each source: set, mask in, clear only after recovery and read
        for (int i = 0; i < 4; i++)
        begin
            bit_v = 32'h1 << i;
            fault_in <= sps_pkg::sps_fault_t'(bit_v[3:0]);
            idle(8);
            rd(sps_pkg::OFF_STATUS, bit_v, 1'b0, "status set");
            pins(3'b111, "masked out");
            wr(sps_pkg::OFF_MASK, bit_v, 1'b0);
            idle(4);
            pins(3'b101, "masked in");
            wr(sps_pkg::OFF_STATUS, bit_v, 1'b0);
            rd(sps_pkg::OFF_STATUS, bit_v, 1'b0, "held by cause");
            fault_in <= '0;
            idle(8);
            wr(sps_pkg::OFF_STATUS, bit_v, 1'b0);
            rd(sps_pkg::OFF_STATUS, bit_v, 1'b0, "held by latch");
            HOST.ack_sources(q);
            check(q, bit_v, "source latch");
            wr(sps_pkg::OFF_STATUS, bit_v, 1'b0);
            rd(sps_pkg::OFF_STATUS, 32'h0, 1'b0, "status cleared");
            idle(2);
            pins(3'b111, "interrupt released");
            wr(sps_pkg::OFF_MASK, 32'h0, 1'b0);
        end
        // Undervoltage with Stop selected, then recovery
        main_uv_in <= 1'b1;
        idle(8);
        pins(3'b001, "stop undervoltage pins");
        rd(sps_pkg::OFF_MODE, 32'h2, 1'b0, "reset stop mode");
        main_uv_in <= 1'b0;
        idle(8);
        rd(sps_pkg::OFF_MODE, 32'h0, 1'b0, "restart request");
        HOST.kick_watchdog();
        // Sleep selected but battery flag still set: Stop path
        wr(sps_pkg::OFF_CTRL, 32'h1, 1'b0);
        main_uv_in <= 1'b1;
        idle(8);
        rd(sps_pkg::OFF_MODE, 32'h2, 1'b0, "flag set keeps stop");
        main_uv_in <= 1'b0;
        idle(8);
        HOST.kick_watchdog();
        wr(sps_pkg::OFF_CTRL, 32'h3, 1'b0);
        rd(sps_pkg::OFF_CTRL, 32'h3, 1'b0, "battery flag cleared");
        main_uv_in <= 1'b1;
        idle(8);
        rd(sps_pkg::OFF_MODE, 32'h3, 1'b0, "reset sleep mode");
        pins(3'b001, "sleep hold pins");
        main_uv_in <= 1'b0;
        idle(1000);
        rd(sps_pkg::OFF_MODE, 32'h3, 1'b0, "hold runs on");
        pins(3'b001, "hold pins stay");
        // Second reset in mid-hold: only reset leaves the sleep path
        srst <= 1'b1;
        idle(2);
        srst <= 1'b0;
        idle(2);
        pins(3'b010, "pins after second reset");
        check({29'h0, power_out}, 32'h5, "power after second reset");
        rd(sps_pkg::OFF_MODE, 32'h0, 1'b0, "mode after second reset");
        rd(sps_pkg::OFF_CTRL, 32'h4, 1'b0, "battery flag set again");
        check(HOST.hangs, 32'h0, "slave inserted wait states");
        end_sim();
    end
endmodule
